// ==== rtl/dsd_decoder.sv ====
/*
  Data space decoder and access sequencer: maps each data address to
  register file, standard I/O, extended I/O, internal SRAM or external
  SRAM, times the access and drives the external SRAM strobes.
  Assumes the core issues one request at a time on clk and waits for
  acc_done; external pins are synchronised here.
*/
`timescale 1ns/1ps
// Functional notes
// - Normal map: 32 RF, 64 IO, 160 XIO, 1024 SRAM
// - Compat map: 96 RF/IO then 1024 SRAM
// - Short IO opcodes never reach extended IO
// - Compat mode: no XIO, SRAM follows IO
// - External SRAM fills rest of 64K
// - Above internal memory routes to external SRAM
// - Strobes idle during internal accesses
// - External access only with enable bit set
// - External byte zero-wait costs one extra cycle
// - External stack PC transfer costs three extra
// - Wait states: two, three, four extra cycles
// - Stack with waits: five, seven, nine extra
// - Top three register pairs are pointers
// - Displacement up to 63 on Y or Z
// - Pre-decrement and post-increment write the stepped value back to the pointer
// - Direct addressing reaches whole data space
// - Internal access takes two cycles
module dsd_decoder
  import dsd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        compat_mode_pin,
  input  wire logic        external_memory_enable_bit,
  input  wire logic [1:0]  wait_state_sel,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_short_io,
  input  wire logic [5:0]  req_io_index,
  input  wire dsd_mode_t   req_mode,
  input  wire dsd_ptr_t    req_ptr,
  input  wire logic [5:0]  req_disp,
  input  wire logic [15:0] req_addr,
  input  wire logic        req_pc_xfer,
  input  wire logic [7:0]  req_wdata,
  input  wire logic        ptr_load,
  input  wire dsd_ptr_t    ptr_load_sel,
  input  wire logic [15:0] ptr_load_value,
  input  wire logic [7:0]  ext_rdata,
  output logic             acc_busy,
  output logic             acc_done,
  output logic             acc_fault,
  output dsd_tgt_t         acc_target,
  output logic [15:0]      acc_addr,
  output logic             acc_write,
  output logic [7:0]       acc_wdata,
  output logic [7:0]       acc_rdata,
  output logic             compat_active,
  output logic [15:0]      ptr_x,
  output logic [15:0]      ptr_y,
  output logic [15:0]      ptr_z,
  output logic             external_read_strobe_pin_n,
  output logic             external_write_strobe_pin_n,
  output logic [15:0]      ext_addr,
  output logic [7:0]       ext_wdata,
  output logic             ext_data_oe
);

  // Total cycles of one access, internal or external
  function automatic logic [3:0] dsd_cycles(input logic ext, input logic pc,
                                            input logic [1:0] ws);
    logic [3:0] w;
    w = {2'b00, ws};
    if (!ext)
      dsd_cycles = INT_CYCLES;
    else if (pc)
      dsd_cycles = INT_CYCLES + EXT_PC_X + (w << 1);
    else
      dsd_cycles = INT_CYCLES + EXT_BYTE_X + w;
  endfunction : dsd_cycles

  logic        mode_s1;        // Strap synchroniser, first stage
  logic        mode_s2;        // Strap synchroniser, second stage
  logic        cfg_locked;     // Map mode captured
  logic [7:0]  rd_s1;          // Read data synchroniser, first stage
  logic [7:0]  rd_s2;          // Read data synchroniser, second stage
  logic [3:0]  cnt;            // Cycles left in current access
  logic        ext_live;       // Current access drives the pins
  logic        take;           // Request accepted this cycle
  logic [15:0] base;           // Selected pointer value
  logic [15:0] next_addr;      // Effective address of the request
  dsd_tgt_t    next_tgt;       // Region of the effective address
  logic        next_ext;       // External target
  logic        next_gated;     // External target with interface off
  logic        step_en;        // Pointer auto step
  logic        step_down;      // Step direction

  // Strap synchroniser, kept out of reset so the pin is through both
  // stages when reset lets go; only stage two reads stage one
  always_ff @(posedge clk)
  begin
    mode_s1 <= compat_mode_pin;
    mode_s2 <= mode_s1;
  end

  // Map mode caught on the first cycle after reset, then frozen
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      compat_active <= 1'b0;
      cfg_locked    <= 1'b0;
    end
    else if (!cfg_locked)
    begin
      compat_active <= mode_s2;
      cfg_locked    <= 1'b1;
    end
  end

  // External read data synchroniser
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_s1 <= 8'h00;
      rd_s2 <= 8'h00;
    end
    else
    begin
      rd_s1 <= ext_rdata;
      rd_s2 <= rd_s1;
    end
  end

  // Pointer pairs live in their own store
  dsd_ptr_regs i_dsd_ptr_regs (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .load_en    (ptr_load && !acc_busy && !take),
    .load_sel   (ptr_load_sel),
    .load_value (ptr_load_value),
    .step_en    (step_en),
    .step_sel   (req_ptr),
    .step_down  (step_down),
    .ptr_x      (ptr_x),
    .ptr_y      (ptr_y),
    .ptr_z      (ptr_z)
  );

  // Accept only once the map is fixed and the last access is over
  assign take = req_valid && cfg_locked && !acc_busy;

  // Effective address from the addressing mode
  always_comb
  begin
    unique case (req_ptr)
      PTR_Y:   base = ptr_y;
      PTR_Z:   base = ptr_z;
      default: base = ptr_x;   // Code 3 is illegal; fall back to X
    endcase
    step_en   = 1'b0;
    step_down = 1'b0;
    if (req_short_io)
      next_addr = STDIO_BASE + {10'h000, req_io_index};
    else
    begin
      unique case (req_mode)
        MODE_DIRECT:
          next_addr = req_addr;
        MODE_INDIRECT:
          next_addr = base;
        MODE_DISP:
          // X has no displacement form; the offset is dropped for it
          next_addr = (req_ptr == PTR_X) ? base
                    : base + {10'h000, req_disp & DISP_MAX};
        MODE_PREDEC:
        begin
          next_addr = base - 16'h0001;
          step_en   = take;
          step_down = 1'b1;
        end
        MODE_POSTINC:
        begin
          next_addr = base;
          step_en   = take;
        end
        default:
          next_addr = req_addr;
      endcase
    end
  end

  // Region decode for the active map
  always_comb
  begin
    if (next_addr < STDIO_BASE)
      next_tgt = TGT_RF;
    else if (next_addr < XIO_BASE)
      next_tgt = TGT_STDIO;
    else if (compat_active)
      next_tgt = (next_addr < EXT_COMP) ? TGT_ISRAM : TGT_EXT;
    else if (next_addr <= XIO_LAST)
      next_tgt = TGT_XIO;
    else if (next_addr < EXT_NORM)
      next_tgt = TGT_ISRAM;
    else
      next_tgt = TGT_EXT;
    next_ext   = (next_tgt == TGT_EXT) && external_memory_enable_bit;
    next_gated = (next_tgt == TGT_EXT) && !external_memory_enable_bit;
  end

  // Access sequencer: count down, pulse done on the last cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      acc_busy  <= 1'b0;
      acc_done  <= 1'b0;
      acc_fault <= 1'b0;
      cnt       <= 4'h0;
      ext_live  <= 1'b0;
    end
    else if (take)
    begin
      acc_busy  <= 1'b1;
      acc_done  <= 1'b0;
      acc_fault <= 1'b0;
      cnt       <= dsd_cycles(next_ext, req_pc_xfer, wait_state_sel) - 4'h1;
      ext_live  <= next_ext;
    end
    else if (acc_busy)
    begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1)
      begin
        acc_busy  <= 1'b0;
        acc_done  <= 1'b1;
        acc_fault <= (acc_target == TGT_EXT) && !ext_live;
        ext_live  <= 1'b0;
      end
    end
    else
    begin
      acc_done  <= 1'b0;
      acc_fault <= 1'b0;
    end
  end

  // Request fields held for the core for the whole access
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      acc_target <= TGT_RF;
      acc_addr   <= 16'h0000;
      acc_write  <= 1'b0;
      acc_wdata  <= 8'h00;
    end
    else if (take)
    begin
      acc_target <= next_tgt;
      acc_addr   <= next_addr;
      acc_write  <= req_write;
      acc_wdata  <= req_wdata;
    end
  end

  // External read data taken at the end of the strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      acc_rdata <= 8'h00;
    else if (acc_busy && ext_live && !acc_write && cnt == 4'h1)
      acc_rdata <= rd_s2;
  end

  // Strobes low only for a live external access; internal ones leave them high
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      external_read_strobe_pin_n  <= 1'b1;
      external_write_strobe_pin_n <= 1'b1;
      ext_data_oe                 <= 1'b0;
    end
    else if (take)
    begin
      external_read_strobe_pin_n  <= !(next_ext && !req_write);
      external_write_strobe_pin_n <= !(next_ext && req_write);
      ext_data_oe                 <= next_ext && req_write;
    end
    else if (acc_busy && cnt == 4'h1)
    begin
      external_read_strobe_pin_n  <= 1'b1;
      external_write_strobe_pin_n <= 1'b1;
      ext_data_oe                 <= 1'b0;
    end
  end

  // Pin address and data follow the accepted request when external
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ext_addr  <= 16'h0000;
      ext_wdata <= 8'h00;
    end
    else if (take && next_ext)
    begin
      ext_addr  <= next_addr;
      ext_wdata <= req_wdata;
    end
  end

  // Internal access ends two cycles after acceptance
  int_time_a: assert property (@(posedge clk) disable iff (sys_rst)
    take && !next_ext |-> ##2 acc_done)
    else $error("internal access not two cycles");

  // Zero-wait external byte takes one more
  ext_byte_a: assert property (@(posedge clk) disable iff (sys_rst)
    take && next_ext && !req_pc_xfer && wait_state_sel == 2'd0
    |-> ##1 !acc_done [*2] ##1 acc_done)
    else $error("external byte not three cycles");

  // Zero-wait program counter transfer takes three more
  ext_pc_a: assert property (@(posedge clk) disable iff (sys_rst)
    take && next_ext && req_pc_xfer && wait_state_sel == 2'd0
    |-> ##1 !acc_done [*4] ##1 acc_done)
    else $error("external PC transfer not five cycles");

  // Three wait states on a byte add four
  wait_byte_a: assert property (@(posedge clk) disable iff (sys_rst)
    take && next_ext && !req_pc_xfer && wait_state_sel == 2'd3
    |-> ##6 acc_done)
    else $error("three-wait byte not six cycles");

  // Three wait states on a PC transfer add nine
  wait_pc_a: assert property (@(posedge clk) disable iff (sys_rst)
    take && next_ext && req_pc_xfer && wait_state_sel == 2'd3
    |-> ##11 acc_done)
    else $error("three-wait PC transfer not eleven cycles");

  // No strobe while an internal target is in service
  strobe_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    acc_busy && acc_target != TGT_EXT
    |-> external_read_strobe_pin_n && external_write_strobe_pin_n)
    else $error("strobe active on internal access");

  // Disabled interface never strobes and reports a fault
  ext_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    take && next_gated
    |=> external_read_strobe_pin_n && external_write_strobe_pin_n ##1 acc_fault)
    else $error("gated external access misbehaved");

  // Short I/O lands in standard I/O only
  short_io_a: assert property (@(posedge clk) disable iff (sys_rst)
    take && req_short_io |=> acc_target == TGT_STDIO && acc_addr < XIO_BASE)
    else $error("short I/O left standard I/O");

  // Compat map has no extended I/O
  compat_map_a: assert property (@(posedge clk) disable iff (sys_rst)
    take && compat_active && next_addr >= ISRAM_COMP && next_addr < EXT_COMP
    |=> acc_target == TGT_ISRAM)
    else $error("compat address not internal SRAM");

  // Post-increment steps the pair after using the old value
  post_inc_a: assert property (@(posedge clk) disable iff (sys_rst)
    take && !req_short_io && req_mode == MODE_POSTINC && req_ptr == PTR_Z
    |=> ptr_z == $past(ptr_z) + 16'h0001 && acc_addr == $past(ptr_z))
    else $error("post-increment wrong");

  // Map mode never changes once captured
  mode_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_locked |=> $stable(compat_active))
    else $error("map mode changed in operation");

endmodule : dsd_decoder

// ==== rtl/dsd_pkg.sv ====
/*
  Constants and types for the data space decoder: region bases and sizes,
  access cycle figures and request encodings.
  Assumes a 16-bit data space and an 8-bit core.
*/
package dsd_pkg;

  // Region sizes
  localparam int unsigned RF_SIZE    = 32;
  localparam int unsigned STDIO_SIZE = 64;
  localparam int unsigned XIO_SIZE   = 160;
  localparam int unsigned ISRAM_SIZE = 1024;
  localparam int unsigned COMPAT_LOW = 96;

  // Region bases, normal map
  localparam logic [15:0] STDIO_BASE  = 16'h0020;
  localparam logic [15:0] XIO_BASE    = 16'h0060;
  localparam logic [15:0] XIO_LAST    = 16'h00ff;
  localparam logic [15:0] ISRAM_NORM  = 16'h0100;
  localparam logic [15:0] EXT_NORM    = 16'h0500;
  // Region bases, compatibility map
  localparam logic [15:0] ISRAM_COMP  = 16'h0060;
  localparam logic [15:0] EXT_COMP    = 16'h0460;

  // Access cycle figures, displacement limit and pointer reset value
  localparam logic [3:0]  INT_CYCLES  = 4'h2;
  localparam logic [3:0]  EXT_BYTE_X  = 4'h1;
  localparam logic [3:0]  EXT_PC_X    = 4'h3;
  localparam logic [5:0]  DISP_MAX    = 6'h3f;
  localparam logic [15:0] PTR_RESET   = 16'h0000;

  // Addressing modes
  typedef enum logic [2:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_DISP,
    MODE_PREDEC,
    MODE_POSTINC
  } dsd_mode_t;

  // Pointer pairs in the top six working registers
  typedef enum logic [1:0] {
    PTR_X,
    PTR_Y,
    PTR_Z
  } dsd_ptr_t;

  // Access targets
  typedef enum logic [2:0] {
    TGT_RF,
    TGT_STDIO,
    TGT_XIO,
    TGT_ISRAM,
    TGT_EXT
  } dsd_tgt_t;

endpackage : dsd_pkg

// ==== rtl/dsd_ptr_regs.sv ====
/*
  Pointer pair store for indirect data addressing.
  Assumes the core loads pairs only while no access is being taken.
*/
`timescale 1ns/1ps
module dsd_ptr_regs
  import dsd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        load_en,
  input  wire dsd_ptr_t    load_sel,
  input  wire logic [15:0] load_value,
  input  wire logic        step_en,
  input  wire dsd_ptr_t    step_sel,
  input  wire logic        step_down,
  output logic      [15:0] ptr_x,
  output logic      [15:0] ptr_y,
  output logic      [15:0] ptr_z
);

  logic [15:0] ptr_q [3];  // X, Y, Z pairs

  // One flop group per pair; a step beats a load in the same cycle
  for (genvar i = 0; i < 3; i++)
  begin : g_pair
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        ptr_q[i] <= PTR_RESET;
      else if (step_en && step_sel == dsd_ptr_t'(i))
        ptr_q[i] <= step_down ? ptr_q[i] - 16'h0001 : ptr_q[i] + 16'h0001;
      else if (load_en && load_sel == dsd_ptr_t'(i))
        ptr_q[i] <= load_value;
    end
  end

  assign ptr_x = ptr_q[0];
  assign ptr_y = ptr_q[1];
  assign ptr_z = ptr_q[2];

endmodule : dsd_ptr_regs

// ==== testbench/dsd_sram_model.sv ====
/*
  External asynchronous SRAM model facing the decoder's memory pins.
  Assumes active-low strobes and a data bus with no pull, so a read
  that has ended shows the inverse of the last byte driven.
*/
`timescale 1ns/1ps
module dsd_sram_model
  import dsd_pkg::*;
(
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_wdata,
  input  wire logic        ext_data_oe,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  output logic      [7:0]  ext_rdata
);
  logic [7:0] mem [0:65535]; // Storage array
  logic [7:0] held = 8'h00;  // Last byte put on the bus

  // Write through while strobe low and data driven
  always @* if (!wr_n && ext_data_oe) mem[ext_addr] = ext_wdata;

  // Remember the byte driven when the read ends
  always @(posedge rd_n) held = mem[ext_addr];

  // Released bus never shows a stale byte
  assign ext_rdata = !rd_n ? mem[ext_addr] : ~held;
endmodule : dsd_sram_model

// ==== testbench/data_space_decoder_bench.sv ====
/*
  Self-checking bench for the data space decoder: map, timing, strobes,
  pointer modes, compat map. Assumes dsd_pkg and the SRAM model first.
*/
`timescale 1ns/1ps
module data_space_decoder_bench;
  import dsd_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, compat_mode_pin = 1'b0;
  logic external_memory_enable_bit = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic req_short_io = 1'b0, req_pc_xfer = 1'b0, ptr_load = 1'b0;
  logic [1:0]  wait_state_sel = 2'h0;
  logic [5:0]  req_io_index = 6'h00, req_disp = 6'h00;
  dsd_mode_t   req_mode = MODE_DIRECT;
  dsd_ptr_t    req_ptr = PTR_X, ptr_load_sel = PTR_X;
  logic [15:0] req_addr = 16'h0000, ptr_load_value = 16'h0000;
  logic [7:0]  req_wdata = 8'h00, ext_rdata;
  logic        acc_busy, acc_done, acc_fault, acc_write, compat_active, ext_data_oe;
  logic        external_read_strobe_pin_n, external_write_strobe_pin_n;
  dsd_tgt_t    acc_target;
  logic [15:0] acc_addr, ptr_x, ptr_y, ptr_z, ext_addr;
  logic [7:0]  acc_wdata, acc_rdata, ext_wdata;
  int          error_cnt = 0, samples_checked = 0, cyc; // Counters, access length
  logic        strb, flt; // Strobe seen, fault seen

  dsd_decoder i_dsd_decoder (.clk(clk), .sys_rst(sys_rst), .compat_mode_pin(compat_mode_pin),
    .external_memory_enable_bit(external_memory_enable_bit), .wait_state_sel(wait_state_sel),
    .req_valid(req_valid), .req_write(req_write), .req_short_io(req_short_io),
    .req_io_index(req_io_index), .req_mode(req_mode), .req_ptr(req_ptr), .req_disp(req_disp),
    .req_addr(req_addr), .req_pc_xfer(req_pc_xfer), .req_wdata(req_wdata),
    .ptr_load(ptr_load), .ptr_load_sel(ptr_load_sel), .ptr_load_value(ptr_load_value),
    .ext_rdata(ext_rdata), .acc_busy(acc_busy), .acc_done(acc_done), .acc_fault(acc_fault),
    .acc_target(acc_target), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .compat_active(compat_active),
    .ptr_x(ptr_x), .ptr_y(ptr_y), .ptr_z(ptr_z),
    .external_read_strobe_pin_n(external_read_strobe_pin_n),
    .external_write_strobe_pin_n(external_write_strobe_pin_n),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_data_oe(ext_data_oe));

  dsd_sram_model i_dsd_sram_model (.ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_data_oe(ext_data_oe), .rd_n(external_read_strobe_pin_n),
    .wr_n(external_write_strobe_pin_n), .ext_rdata(ext_rdata));

  // 10 MHz clock
  always #50 clk = ~clk;

  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // Value compare, four-state exact
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Reset for 20 cycles with a chosen map pin, then let the map lock
  task automatic do_reset(input logic cm);
    @(negedge clk);
    compat_mode_pin = cm;
    sys_rst = 1'b1;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask : do_reset

  // One request; counts cycles to done, notes strobes and fault
  task automatic rq(input logic w, input logic [15:0] a, input dsd_mode_t m,
                    input dsd_ptr_t p, input logic [5:0] d, input logic pc);
    @(negedge clk);
    req_write = w;
    req_addr = a;
    req_mode = m;
    req_ptr = p;
    req_disp = d;
    req_pc_xfer = pc;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    cyc = 1;
    strb = 1'b0;
    // Bounded wait; strobes sampled each busy cycle
    while (acc_done !== 1'b1 && cyc < 40)
    begin
      strb = strb | ~external_read_strobe_pin_n | ~external_write_strobe_pin_n;
      @(negedge clk);
      cyc++;
    end
    flt = acc_fault;
  endtask : rq

  // Direct access: target, length, strobes
  task automatic map_run(input logic [15:0] a, input dsd_tgt_t t);
    rq(1'b0, a, MODE_DIRECT, PTR_X, 6'h00, 1'b0);
    chk(16'(acc_target), 16'(t));
    chk(16'(cyc), (t == TGT_EXT) ? 16'h0003 : 16'h0002);
    chk(16'(strb), (t == TGT_EXT) ? 16'h0001 : 16'h0000);
  endtask : map_run

  // Normal map boundaries
  task automatic t_map;
    map_run(16'h001f, TGT_RF);
    map_run(16'h0020, TGT_STDIO);
    map_run(16'h005f, TGT_STDIO);
    map_run(16'h0060, TGT_XIO);
    map_run(16'h00ff, TGT_XIO);
    map_run(16'h0100, TGT_ISRAM);
    map_run(16'h04ff, TGT_ISRAM);
    map_run(16'h0500, TGT_EXT);
    map_run(16'hffff, TGT_EXT);
    $display("test map done");
  endtask : t_map

  // Short I/O index 63 stays in standard I/O
  task automatic t_short;
    req_short_io = 1'b1;
    req_io_index = 6'h3f;
    rq(1'b0, 16'h00c0, MODE_DIRECT, PTR_X, 6'h00, 1'b0);
    req_short_io = 1'b0;
    chk(acc_addr, 16'h005f);
    chk(16'(acc_target), 16'(TGT_STDIO));
    $display("test short io done");
  endtask : t_short

  // Every wait-state code, byte and PC transfer, then read back
  task automatic t_waits;
    for (int ws = 0; ws < 4; ws++)
    begin
      wait_state_sel = 2'(ws);
      req_wdata = 8'h5a + 8'(ws);
      rq(1'b1, 16'h1234, MODE_DIRECT, PTR_X, 6'h00, 1'b0);
      chk(16'(cyc), 16'(3 + ws));
      chk(ext_addr, 16'h1234);
      chk(16'(ext_wdata), 16'(8'h5a + 8'(ws)));
      chk(16'(acc_write), 16'h0001);
      chk(16'(acc_wdata), 16'(8'h5a + 8'(ws)));
      rq(1'b1, 16'h2000, MODE_DIRECT, PTR_X, 6'h00, 1'b1);
      chk(16'(cyc), 16'(5 + 2 * ws));
    end
    rq(1'b0, 16'h1234, MODE_DIRECT, PTR_X, 6'h00, 1'b0);
    chk(16'(acc_rdata), 16'h005d);
    $display("test wait states done");
  endtask : t_waits

  // Enable bit low: no strobes, fault with done
  task automatic t_noext;
    wait_state_sel = 2'h0;
    external_memory_enable_bit = 1'b0;
    rq(1'b1, 16'h8000, MODE_DIRECT, PTR_X, 6'h00, 1'b0);
    external_memory_enable_bit = 1'b1;
    chk(16'(strb), 16'h0000);
    chk(16'(flt), 16'h0001);
    chk(16'(cyc), 16'h0002);
    $display("test enable low done");
  endtask : t_noext

  // Pointer load while idle
  task automatic pload(input dsd_ptr_t s, input logic [15:0] v);
    @(negedge clk);
    ptr_load = 1'b1;
    ptr_load_sel = s;
    ptr_load_value = v;
    @(negedge clk);
    ptr_load = 1'b0;
  endtask : pload

  // Displacement, indirect, post-increment, pre-decrement
  task automatic t_ptr;
    pload(PTR_Y, 16'h0100);
    rq(1'b0, 16'h0000, MODE_DISP, PTR_Y, 6'h3f, 1'b0);
    chk(acc_addr, 16'h013f);
    rq(1'b0, 16'h0000, MODE_INDIRECT, PTR_Y, 6'h00, 1'b0);
    chk(acc_addr, 16'h0100);
    chk(ptr_y, 16'h0100);
    pload(PTR_Z, 16'h04ff);
    rq(1'b0, 16'h0000, MODE_POSTINC, PTR_Z, 6'h00, 1'b0);
    chk(acc_addr, 16'h04ff);
    chk(ptr_z, 16'h0500);
    pload(PTR_X, 16'h0501);
    rq(1'b0, 16'h0000, MODE_PREDEC, PTR_X, 6'h00, 1'b0);
    chk(acc_addr, 16'h0500);
    chk(ptr_x, 16'h0500);
    chk(16'(acc_target), 16'(TGT_EXT));
    $display("test pointers done");
  endtask : t_ptr

  // Compat map, then pin change ignored
  task automatic t_compat;
    do_reset(1'b1);
    chk(16'(compat_active), 16'h0001);
    map_run(16'h005f, TGT_STDIO);
    map_run(16'h0060, TGT_ISRAM);
    map_run(16'h045f, TGT_ISRAM);
    map_run(16'h0460, TGT_EXT);
    compat_mode_pin = 1'b0;
    repeat (5) @(negedge clk);
    map_run(16'h0100, TGT_ISRAM);
    chk(16'(compat_active), 16'h0001);
    $display("test compat done");
  endtask : t_compat

  // Main sequence
  initial
  begin
    do_reset(1'b0);
    t_map;
    t_short;
    t_waits;
    t_noext;
    t_ptr;
    t_compat;
    results;
  end

  // Watchdog, far beyond the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results;
  end
endmodule : data_space_decoder_bench
